/* File: dspace_pkg.sv */
// Purpose: Shared constants and types for the data space decoder
// Assumes: 8-bit data, 16-bit data addresses, one 250 MHz clock
// Notes:   Regions are linear and back to back
package dspace_pkg;
  localparam int unsigned REG_BASE     = 0;
  localparam int unsigned REG_SIZE     = 32;
  localparam int unsigned IO_SIZE      = 64;
  localparam int unsigned XIO_SIZE     = 160;
  localparam int unsigned SRAM_SIZE    = 1024;
  localparam int unsigned IO_BASE      = REG_BASE + REG_SIZE;
  localparam int unsigned XIO_BASE     = IO_BASE + IO_SIZE;
  localparam int unsigned SRAM_BASE    = XIO_BASE + XIO_SIZE;
  localparam int unsigned DATA_TOP     = SRAM_BASE + SRAM_SIZE;
  localparam logic [5:0]  IO_OFFSET    = 6'h20;
  localparam logic [5:0]  IO_LAST      = 6'h3F;
  localparam logic [5:0]  IO_BIT_LAST  = 6'h1F;
  localparam logic [5:0]  MAX_DISP     = 6'h3F;
  localparam logic [5:0]  SCRATCH0_IO  = 6'h14;
  localparam logic [5:0]  SCRATCH1_IO  = 6'h15;
  localparam logic [5:0]  SCRATCH2_IO  = 6'h16;
  localparam logic [4:0]  PTR_X_LO     = 5'h1A;
  localparam logic [4:0]  PTR_Y_LO     = 5'h1C;
  localparam logic [4:0]  PTR_Z_LO     = 5'h1E;
  localparam int unsigned PROG_WORDS   = 8192;
  localparam int unsigned PC_WIDTH     = 13;
  localparam int unsigned NV_BYTES     = 256;
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned NV_OSC_MHZ   = 8;
  localparam int unsigned NV_TICK_DIV  = CLK_MHZ / NV_OSC_MHZ;
  localparam logic [7:0]  SCRATCH_RST  = 8'h00;

  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_LOAD   = 3'h1,
    OP_STORE  = 3'h2,
    OP_IO_IN  = 3'h3,
    OP_IO_OUT = 3'h4,
    OP_BIT_SET = 3'h5,
    OP_BIT_CLR = 3'h6,
    OP_BIT_TST = 3'h7
  } op_t;

  typedef enum logic [2:0] {
    AM_DIRECT   = 3'h0,
    AM_INDIRECT = 3'h1,
    AM_DISP     = 3'h2,
    AM_PREDEC   = 3'h3,
    AM_POSTINC  = 3'h4
  } amode_t;

  typedef enum logic [2:0] {
    RG_REGS = 3'h0,
    RG_IO   = 3'h1,
    RG_XIO  = 3'h2,
    RG_SRAM = 3'h3,
    RG_NONE = 3'h4
  } region_t;

  typedef enum logic [1:0] {
    PTR_X = 2'h0,
    PTR_Y = 2'h1,
    PTR_Z = 2'h2
  } ptr_t;
endpackage

/* File: sram_if.sv */
// Purpose: Request and answer wires between decoder and SRAM array
// Assumes: One request per cycle at most, answer one cycle later
// Notes:   Index is relative to the start of SRAM
`timescale 1ns/10ps
interface sram_if #(parameter int AW = 10);
  logic          req;
  logic          we;
  logic [AW-1:0] index;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  modport ctrl (output req, output we, output index, output wdata,
                input rdata);
  modport mem  (input req, input we, input index, input wdata,
                output rdata);
endinterface

/* File: sram_array.sv */
// Purpose: Internal data SRAM built from flip-flops
// Assumes: Synchronous read, data valid the cycle after the request
// Notes:   Contents are not cleared by reset, as in a real SRAM
`timescale 1ns/10ps
module sram_array #(
  parameter int DEPTH = dspace_pkg::SRAM_SIZE,
  parameter int AW    = 10
) (
  // Clock
  input wire logic clk,
  // Port
  sram_if.mem      bus
);
  logic [7:0] mem_q [DEPTH];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] wr_d;
  logic       wr_en;

  always_comb begin
    rdata_d = rdata_q;
    wr_en   = bus.req && bus.we;
    wr_d    = bus.wdata;
    if (bus.req && !bus.we) begin
      rdata_d = mem_q[bus.index];
    end
  end

  always_ff @(posedge clk) begin
    rdata_q <= rdata_d;
    if (wr_en) begin
      mem_q[bus.index] <= wr_d;
    end
  end

  assign bus.rdata = rdata_q;
endmodule

/* File: data_space_address_decoder.sv */
// Purpose: Decode processor data accesses onto registers, I/O and SRAM
// Assumes: Core holds a request stable until done; inputs synchronous
// Notes:   Peripheral I/O lives outside; this block routes to it
`timescale 1ns/10ps

// Notes on behaviour
// [R1] Lowest 32 addresses reach working registers
// [R2] Next 64 addresses are short I/O
// [R3] Next 160 addresses are extended I/O
// [R4] Next 1024 are SRAM, 1280 total
// [R5] I/O instructions address 0x00 to 0x3F
// [R6] Loads and stores see I/O at +0x20
// [R7] Bit operations only on I/O 0x00-0x1F
// [R8] Extended I/O only by load and store
// [R9] SRAM access takes two clock cycles
// [R10] Displacement reaches base plus up to 63
// [R11] Pre-decrement pointer before use
// [R12] Post-increment pointer after use
// [R13] All modes reach every volatile region
// [R14] Three scratch registers, bit accessible
// [R15] Program memory 8192 words, 13-bit counter
// [R16] Separate 256-byte nonvolatile byte space
// [R17] Nonvolatile timing from 8 MHz tick
// [R18] Software writes reserved bits as zero
// [R19] Unmapped reads zero, writes ignored
module data_space_address_decoder #(
  parameter int unsigned SRAM_DEPTH = dspace_pkg::SRAM_SIZE,
  parameter int unsigned PC_W       = dspace_pkg::PC_WIDTH
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Core request
  input  wire logic        reqValid,
  input  wire logic [2:0]  reqOp,
  input  wire logic [2:0]  reqMode,
  input  wire logic [15:0] reqAddr,
  input  wire logic [1:0]  reqPtr,
  input  wire logic [5:0]  reqDisp,
  input  wire logic [2:0]  reqBit,
  input  wire logic [7:0]  reqWdata,
  // Core answer
  output logic             rspDone,
  output logic [7:0]       rspRdata,
  output logic             rspBitVal,
  output logic             rspIllegal,
  output logic [15:0]      rspAddr,
  // Peripheral I/O port (short and extended regions)
  output logic             perReq,
  output logic             perWe,
  output logic [7:0]       perIndex,
  output logic [7:0]       perWdata,
  input  wire logic [7:0]  perRdata,
  input  wire logic        perPresent,
  // Program counter and nonvolatile space
  input  wire logic        pcLoad,
  input  wire logic [15:0] pcValue,
  output logic [12:0]      programCounter,
  input  wire logic [7:0]  nvAddrIn,
  output logic [7:0]       nvAddr,
  output logic             nvTick
);
  // Working register file; pointers live at the top
  logic [7:0]  regs_q [32];
  logic [7:0]  regs_d [32];
  logic [7:0]  scratch_q [3];
  logic [7:0]  scratch_d [3];

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b11
  } state_t;
  state_t      state_q, state_d;

  logic        done_q, done_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        bitv_q, bitv_d;
  logic        ill_q, ill_d;
  logic [15:0] addr_q, addr_d;
  logic        perReq_q, perReq_d;
  logic        perWe_q, perWe_d;
  logic [7:0]  perIdx_q, perIdx_d;
  logic [7:0]  perWd_q, perWd_d;
  logic        perRd_q, perRd_d;
  logic [2:0]  bit_q, bit_d;
  logic [2:0]  op_q, op_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [7:0]  nv_q, nv_d;
  logic [4:0]  div_q, div_d;
  logic        tick_q, tick_d;

  sram_if #(.AW(10)) sbus ();

  sram_array #(.DEPTH(SRAM_DEPTH), .AW(10)) u_sram (
    .clk (clk),
    .bus (sbus)
  );

  // Which region a flat data address falls in
  function automatic dspace_pkg::region_t region_of(input logic [15:0] a);
    if (a < 16'(dspace_pkg::IO_BASE)) begin
      return dspace_pkg::RG_REGS; // R1
    end else if (a < 16'(dspace_pkg::XIO_BASE)) begin
      return dspace_pkg::RG_IO; // R2
    end else if (a < 16'(dspace_pkg::SRAM_BASE)) begin
      return dspace_pkg::RG_XIO; // R3
    end else if (a < 16'(dspace_pkg::DATA_TOP)) begin
      return dspace_pkg::RG_SRAM; // R4
    end
    return dspace_pkg::RG_NONE; // R19
  endfunction

  function automatic logic [4:0] ptr_lo(input logic [1:0] p);
    unique case (p)
      dspace_pkg::PTR_X: return dspace_pkg::PTR_X_LO;
      dspace_pkg::PTR_Y: return dspace_pkg::PTR_Y_LO;
      default:           return dspace_pkg::PTR_Z_LO;
    endcase
  endfunction

  // Scratch slot for a short I/O address, 3 when none
  function automatic logic [1:0] scratch_slot(input logic [5:0] io);
    if (io == dspace_pkg::SCRATCH0_IO) return 2'd0;
    if (io == dspace_pkg::SCRATCH1_IO) return 2'd1;
    if (io == dspace_pkg::SCRATCH2_IO) return 2'd2;
    return 2'd3;
  endfunction

  logic [4:0]  pLo;
  logic [15:0] ptrVal;
  logic [15:0] effAddr;
  logic [15:0] ptrNew;
  logic        ptrWb;
  logic        isMem;
  logic        isIoOp;
  logic        isBitOp;
  logic        legal;
  dspace_pkg::region_t rg;
  logic [5:0]  ioIdx;
  logic [1:0]  slot;
  logic [7:0]  cur;
  logic [7:0]  mask;

  always_comb begin
    pLo    = ptr_lo(reqPtr);
    ptrVal = {regs_q[pLo + 5'd1], regs_q[pLo]};
    isMem  = (reqOp == dspace_pkg::OP_LOAD) ||
             (reqOp == dspace_pkg::OP_STORE);
    isBitOp = (reqOp == dspace_pkg::OP_BIT_SET) ||
              (reqOp == dspace_pkg::OP_BIT_CLR) ||
              (reqOp == dspace_pkg::OP_BIT_TST);
    isIoOp = (reqOp == dspace_pkg::OP_IO_IN) ||
             (reqOp == dspace_pkg::OP_IO_OUT) || isBitOp;
    ptrNew = ptrVal;
    ptrWb  = 1'b0;
    effAddr = reqAddr;
    if (isMem) begin
      unique case (reqMode) // R13
        dspace_pkg::AM_INDIRECT: effAddr = ptrVal;
        dspace_pkg::AM_DISP: begin
          effAddr = ptrVal + {10'h000, reqDisp & dspace_pkg::MAX_DISP}; // R10
        end
        dspace_pkg::AM_PREDEC: begin
          ptrNew  = ptrVal - 16'h0001; // R11
          effAddr = ptrNew;
          ptrWb   = 1'b1;
        end
        dspace_pkg::AM_POSTINC: begin
          effAddr = ptrVal; // R12
          ptrNew  = ptrVal + 16'h0001;
          ptrWb   = 1'b1;
        end
        default: effAddr = reqAddr;
      endcase
    end else if (isIoOp) begin
      effAddr = {10'h000, reqAddr[5:0] & dspace_pkg::IO_LAST}
              + {10'h000, dspace_pkg::IO_OFFSET}; // R5 R6
    end
    rg = region_of(effAddr);
    // Bit ops reach only the low half; extended I/O never by short ops
    legal = isMem || (isIoOp && rg == dspace_pkg::RG_IO &&
            (!isBitOp || reqAddr[5:0] <= dspace_pkg::IO_BIT_LAST)); // R7 R8
    ioIdx = 6'(effAddr - 16'(dspace_pkg::IO_BASE));
    slot  = scratch_slot(ioIdx);
    cur   = (slot == 2'd3) ? 8'h00 : scratch_q[slot];
    mask  = 8'h01 << reqBit;
  end

  // Request handling and answer registers
  always_comb begin
    state_d  = state_q;
    done_d   = 1'b0;
    rdata_d  = rdata_q;
    bitv_d   = bitv_q;
    ill_d    = 1'b0;
    addr_d   = addr_q;
    perReq_d = 1'b0;
    perWe_d  = 1'b0;
    perIdx_d = perIdx_q;
    perWd_d  = perWd_q;
    perRd_d  = 1'b0;
    bit_d    = bit_q;
    op_d     = op_q;
    regs_d   = regs_q;
    scratch_d = scratch_q;
    sbus.req   = 1'b0;
    sbus.we    = 1'b0;
    sbus.index = 10'(effAddr - 16'(dspace_pkg::SRAM_BASE));
    sbus.wdata = reqWdata;
    unique case (state_q)
      ST_IDLE: begin
        if (reqValid && reqOp != dspace_pkg::OP_NONE) begin
          addr_d = effAddr;
          bit_d  = reqBit;
          op_d   = reqOp;
          if (ptrWb) begin
            regs_d[pLo]        = ptrNew[7:0];
            regs_d[pLo + 5'd1] = ptrNew[15:8];
          end
          if (!legal) begin
            ill_d   = 1'b1;
            rdata_d = 8'h00;
            done_d  = 1'b1;
            state_d = ST_DONE;
          end else begin
            unique case (rg)
              dspace_pkg::RG_REGS: begin
                rdata_d = regs_q[effAddr[4:0]]; // R1
                if (reqOp == dspace_pkg::OP_STORE) begin
                  regs_d[effAddr[4:0]] = reqWdata;
                end
                done_d  = 1'b1;
                state_d = ST_DONE;
              end
              dspace_pkg::RG_SRAM: begin
                sbus.req = 1'b1; // R9
                sbus.we  = (reqOp == dspace_pkg::OP_STORE);
                state_d  = ST_WAIT;
              end
              dspace_pkg::RG_IO, dspace_pkg::RG_XIO: begin
                if (rg == dspace_pkg::RG_IO && slot != 2'd3) begin
                  rdata_d = cur; // R14
                  bitv_d  = |(cur & mask);
                  unique case (reqOp)
                    dspace_pkg::OP_STORE, dspace_pkg::OP_IO_OUT:
                      scratch_d[slot] = reqWdata;
                    dspace_pkg::OP_BIT_SET:
                      scratch_d[slot] = cur | mask; // R14
                    dspace_pkg::OP_BIT_CLR:
                      scratch_d[slot] = cur & ~mask;
                    default: scratch_d[slot] = cur;
                  endcase
                  done_d  = 1'b1;
                  state_d = ST_DONE;
                end else begin
                  perReq_d = 1'b1;
                  perWe_d  = (reqOp == dspace_pkg::OP_STORE) ||
                             (reqOp == dspace_pkg::OP_IO_OUT);
                  perIdx_d = 8'(effAddr - 16'(dspace_pkg::IO_BASE));
                  perWd_d  = reqWdata;
                  perRd_d  = 1'b1;
                  state_d  = ST_WAIT;
                end
              end
              default: begin
                rdata_d = 8'h00; // R19
                done_d  = 1'b1;
                state_d = ST_DONE;
              end
            endcase
          end
        end
      end
      ST_WAIT: begin
        // Second cycle: SRAM data or peripheral answer is ready
        if (region_of(addr_q) == dspace_pkg::RG_SRAM) begin
          rdata_d = sbus.rdata; // R9
        end else begin
          rdata_d = perPresent ? perRdata : 8'h00; // R19
          bitv_d  = perPresent ? perRdata[bit_q] : 1'b0;
        end
        done_d  = 1'b1;
        state_d = ST_DONE;
      end
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // Program counter wraps within 8192 words
  always_comb begin
    pc_d = pcLoad ? pcValue[PC_W-1:0] : pc_q; // R15
    nv_d = nvAddrIn; // R16
    tick_d = 1'b0;
    div_d  = div_q + 5'd1;
    if (div_q == 5'(dspace_pkg::NV_TICK_DIV - 1)) begin
      div_d  = 5'd0;
      tick_d = 1'b1; // R17
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q  <= ST_IDLE;
      done_q   <= 1'b0;
      rdata_q  <= 8'h00;
      bitv_q   <= 1'b0;
      ill_q    <= 1'b0;
      addr_q   <= 16'h0000;
      perReq_q <= 1'b0;
      perWe_q  <= 1'b0;
      perIdx_q <= 8'h00;
      perWd_q  <= 8'h00;
      perRd_q  <= 1'b0;
      bit_q    <= 3'h0;
      op_q     <= 3'h0;
      pc_q     <= '0;
      nv_q     <= 8'h00;
      div_q    <= 5'h00;
      tick_q   <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        scratch_q[i] <= dspace_pkg::SCRATCH_RST;
      end
      for (int i = 0; i < 32; i++) begin
        regs_q[i] <= 8'h00;
      end
    end else begin
      state_q   <= state_d;
      done_q    <= done_d;
      rdata_q   <= rdata_d;
      bitv_q    <= bitv_d;
      ill_q     <= ill_d;
      addr_q    <= addr_d;
      perReq_q  <= perReq_d;
      perWe_q   <= perWe_d;
      perIdx_q  <= perIdx_d;
      perWd_q   <= perWd_d;
      perRd_q   <= perRd_d;
      bit_q     <= bit_d;
      op_q      <= op_d;
      pc_q      <= pc_d;
      nv_q      <= nv_d;
      div_q     <= div_d;
      tick_q    <= tick_d;
      scratch_q <= scratch_d;
      regs_q    <= regs_d;
    end
  end

  assign rspDone        = done_q;
  assign rspRdata       = rdata_q;
  assign rspBitVal      = bitv_q;
  assign rspIllegal     = ill_q;
  assign rspAddr        = addr_q;
  assign perReq         = perReq_q;
  assign perWe          = perWe_q;
  assign perIndex       = perIdx_q;
  assign perWdata       = perWd_q;
  assign programCounter = pc_q;
  assign nvAddr         = nv_q;
  assign nvTick         = tick_q;
endmodule

/* File: data_space_address_decoder_props.sv */
// Purpose: Port-level timing and routing checks for the decoder
// Assumes: Requests are raised only while the decoder is idle
// Notes:   Bound onto every decoder instance
`timescale 1ns/10ps
module data_space_address_decoder_props (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Core side
  input wire logic        reqValid,
  input wire logic [2:0]  reqOp,
  input wire logic [2:0]  reqMode,
  input wire logic [15:0] reqAddr,
  input wire logic        rspDone,
  input wire logic [7:0]  rspRdata,
  input wire logic        rspIllegal,
  // Peripheral, counter and tick
  input wire logic        perReq,
  input wire logic [7:0]  perIndex,
  input wire logic        pcLoad,
  input wire logic [15:0] pcValue,
  input wire logic [12:0] programCounter,
  input wire logic        nvTick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       tk;
  logic       ld;
  logic [5:0] gap_q;
  logic [5:0] gap_d;
  logic       seen_q;
  logic       seen_d;
  assign tk = reqValid && reqOp != 3'h0;
  assign ld = tk && reqOp == 3'h1 && reqMode == 3'h0;
  always_comb begin
    gap_d = nvTick ? 6'h00 : gap_q + 6'h01;
    seen_d = seen_q | nvTick;
  end
  always_ff @(posedge clk) begin
    gap_q <= rst_n ? gap_d : 6'h00;
    seen_q <= rst_n ? seen_d : 1'b0;
  end
  property p_reg_one;
    ld && reqAddr < 16'h0020 |=> rspDone && !perReq;
  endproperty
  a_reg_one: assert property (p_reg_one)
    else $error("register load not answered in one cycle");
  property p_sram_two;
    ld && reqAddr >= 16'h0100 && reqAddr <= 16'h04FF |=> !rspDone ##1 rspDone;
  endproperty
  a_sram_two: assert property (p_sram_two)
    else $error("SRAM load not answered in two cycles");
  property p_io_map;
    ld && reqAddr >= 16'h0037 && reqAddr <= 16'h005F
      |=> perReq && {8'h00, perIndex} == $past(reqAddr) - 16'h0020;
  endproperty
  a_io_map: assert property (p_io_map)
    else $error("short I/O load routed to wrong index");
  property p_xio_map;
    ld && reqAddr >= 16'h0060 && reqAddr <= 16'h00FF
      |=> perReq && {8'h00, perIndex} == $past(reqAddr) - 16'h0020;
  endproperty
  a_xio_map: assert property (p_xio_map)
    else $error("extended I/O load routed to wrong index");
  property p_io_in;
    tk && reqOp == 3'h3 && reqAddr[5:0] >= 6'h17
      |=> perReq && {8'h00, perIndex} == ($past(reqAddr) & 16'h003F);
  endproperty
  a_io_in: assert property (p_io_in)
    else $error("I/O input routed to wrong index");
  property p_bit_ill;
    tk && reqOp >= 3'h5 && reqAddr[5:0] > 6'h1F
      |=> rspDone && rspIllegal && !perReq;
  endproperty
  a_bit_ill: assert property (p_bit_ill)
    else $error("bit operation above low I/O range not refused");
  property p_unmap;
    ld && reqAddr >= 16'h0500 |=> rspDone && rspRdata == 8'h00 && !perReq;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("load above SRAM did not read zero");
  property p_pc;
    pcLoad |=> {3'h0, programCounter} == ($past(pcValue) & 16'h1FFF);
  endproperty
  a_pc: assert property (p_pc)
    else $error("program counter load wrong");
  property p_tick;
    seen_q |-> nvTick == (gap_q == 6'h1E);
  endproperty
  a_tick: assert property (p_tick)
    else $error("nonvolatile tick spacing wrong");
  c_sram: cover property (ld && reqAddr >= 16'h0100);
  c_ill: cover property (rspIllegal);
  c_tick: cover property (nvTick ##31 nvTick);
endmodule
bind data_space_address_decoder data_space_address_decoder_props u_props (
  .clk(clk), .rst_n(rst_n), .reqValid(reqValid), .reqOp(reqOp),
  .reqMode(reqMode), .reqAddr(reqAddr), .rspDone(rspDone),
  .rspRdata(rspRdata), .rspIllegal(rspIllegal), .perReq(perReq),
  .perIndex(perIndex), .pcLoad(pcLoad), .pcValue(pcValue),
  .programCounter(programCounter), .nvTick(nvTick));

/* File: peri_io_model.sv */
// Purpose: Peripheral register space behind the decoder I/O port
// Assumes: Answer held in the request cycle and the one after
// Notes:   Index 0xDF stands for a reserved, absent location
`timescale 1ns/10ps
module peri_io_model (
  // Clock
  input wire logic        clk,
  // Request
  input wire logic        perReq,
  input wire logic        perWe,
  input wire logic [7:0]  perIndex,
  input wire logic [7:0]  perWdata,
  // Answer
  output logic [7:0]      perRdata,
  output logic            perPresent
);
  logic [7:0] mem [0:223];
  logic       hold_q;
  logic [7:0] idx_q;
  logic [7:0] idx;
  initial for (int i = 0; i < 224; i++) mem[i] = 8'h00;
  always_ff @(posedge clk) begin
    hold_q <= perReq;
    if (perReq) idx_q <= perIndex;
    // Reserved place keeps nothing written to it
    if (perReq && perWe && perIndex != 8'hDF) mem[perIndex] <= perWdata;
  end
  assign idx = perReq ? perIndex : idx_q;
  assign perPresent = (perReq | hold_q) && idx != 8'hDF;
  // Outside the answer window the bus shows the inverse, never stale data
  assign perRdata = (perReq | hold_q) ? mem[idx] : ~mem[idx];
endmodule

/* File: data_space_address_decoder_tb.sv */
// Purpose: Directed checks of decoding, pointer modes and timing
// Assumes: One request at a time, raised only when idle
// Notes:   Each scenario judges its own answers
`timescale 1ns/10ps
module data_space_address_decoder_tb;
  logic clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, pcLoad = 1'b0;
  logic [2:0] reqOp = 3'h0, reqMode = 3'h0, reqBit = 3'h0;
  logic [15:0] reqAddr = 16'h0000, pcValue = 16'h0000;
  logic [1:0] reqPtr = 2'h0;
  logic [5:0] reqDisp = 6'h00;
  logic [7:0] reqWdata = 8'h00, nvAddrIn = 8'h00;
  logic rspDone, rspBitVal, rspIllegal, perReq, perWe, perPresent, nvTick;
  logic [7:0] rspRdata, perIndex, perWdata, perRdata, nvAddr, rd;
  logic [15:0] rspAddr, ea;
  logic [12:0] programCounter;
  logic bv, il;
  int err_count = 0, tests_run = 0, cyc = 0, lat;
  always #2 clk = ~clk;
  data_space_address_decoder dut (.clk, .rst_n, .reqValid, .reqOp,
    .reqMode, .reqAddr, .reqPtr, .reqDisp, .reqBit, .reqWdata, .rspDone,
    .rspRdata, .rspBitVal, .rspIllegal, .rspAddr, .perReq, .perWe,
    .perIndex, .perWdata, .perRdata, .perPresent, .pcLoad, .pcValue,
    .programCounter, .nvAddrIn, .nvAddr, .nvTick);
  peri_io_model peri (.clk, .perReq, .perWe, .perIndex, .perWdata,
    .perRdata, .perPresent);
  task automatic chk(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task complete_run;
    $display("mismatches %0d comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic acc(input logic [2:0] o, m, input logic [15:0] a,
      input logic [7:0] w = 8'h00, input logic [2:0] b = 3'h0,
      input logic [1:0] p = 2'h0, input logic [5:0] d = 6'h00);
    @(posedge clk);
    reqValid <= 1'b1;
    reqOp <= o;
    reqMode <= m;
    reqAddr <= a;
    reqWdata <= w;
    reqBit <= b;
    reqPtr <= p;
    reqDisp <= d;
    @(posedge clk);
    reqValid <= 1'b0;
    // The take edge itself launches a one-cycle answer
    lat = 1;
    #1;
    while (rspDone !== 1'b1 && lat < 9) begin
      @(posedge clk);
      #1;
      lat++;
    end
    chk("rspDone", 16'h0001, {15'h0000, rspDone});
    rd = rspRdata;
    bv = rspBitVal;
    il = rspIllegal;
    ea = rspAddr;
  endtask
  task t_regs;
    acc(3'h2, 3'h0, 16'h0003, 8'h5A);
    chk("reg latency", 16'h0001, 16'(lat));
    acc(3'h2, 3'h0, 16'h001E, 8'h03);
    acc(3'h2, 3'h0, 16'h001F, 8'h00);
    acc(3'h1, 3'h1, 16'h0000, 8'h00, 3'h0, 2'h2);
    chk("indirect reg", 16'h005A, {8'h00, rd});
  endtask
  task t_sram;
    acc(3'h2, 3'h0, 16'h04FF, 8'hC3);
    acc(3'h1, 3'h0, 16'h04FF);
    chk("sram top", 16'h00C3, {8'h00, rd});
    chk("sram latency", 16'h0002, 16'(lat));
    acc(3'h2, 3'h0, 16'h001E, 8'h10);
    acc(3'h2, 3'h0, 16'h001F, 8'h01);
    acc(3'h2, 3'h2, 16'h0000, 8'h77, 3'h0, 2'h2, 6'h3F);
    chk("disp addr", 16'h014F, ea);
    acc(3'h1, 3'h0, 16'h014F);
    chk("disp data", 16'h0077, {8'h00, rd});
    acc(3'h2, 3'h0, 16'h001A, 8'h00);
    acc(3'h2, 3'h0, 16'h001B, 8'h01);
    acc(3'h2, 3'h4, 16'h0000, 8'h99, 3'h0, 2'h0);
    chk("postinc addr", 16'h0100, ea);
    acc(3'h1, 3'h0, 16'h001A);
    chk("postinc ptr", 16'h0001, {8'h00, rd});
    acc(3'h2, 3'h0, 16'h001C, 8'h00);
    acc(3'h2, 3'h0, 16'h001D, 8'h02);
    acc(3'h2, 3'h3, 16'h0000, 8'h44, 3'h0, 2'h1);
    chk("predec addr", 16'h01FF, ea);
    acc(3'h1, 3'h0, 16'h001C);
    chk("predec low", 16'h00FF, {8'h00, rd});
    acc(3'h1, 3'h0, 16'h001D);
    chk("predec high", 16'h0001, {8'h00, rd});
  endtask
  task t_io;
    acc(3'h4, 3'h0, 16'h0005, 8'h3C);
    acc(3'h1, 3'h0, 16'h0025);
    chk("io via load", 16'h003C, {8'h00, rd});
    acc(3'h4, 3'h0, 16'h003F, 8'h12);
    acc(3'h1, 3'h0, 16'h005F);
    chk("last io", 16'h0012, {8'h00, rd});
    acc(3'h2, 3'h0, 16'h0060, 8'h81);
    acc(3'h1, 3'h0, 16'h0060);
    chk("xio", 16'h0081, {8'h00, rd});
    acc(3'h3, 3'h0, 16'h0005);
    chk("io in", 16'h003C, {8'h00, rd});
  endtask
  task t_bits;
    acc(3'h1, 3'h0, 16'h0035);
    chk("scratch reset", 16'h0000, {8'h00, rd});
    acc(3'h4, 3'h0, 16'h0014, 8'h00);
    acc(3'h5, 3'h0, 16'h0014, 8'h00, 3'h3);
    acc(3'h7, 3'h0, 16'h0014, 8'h00, 3'h3);
    chk("bit set", 16'h0001, {15'h0000, bv});
    acc(3'h1, 3'h0, 16'h0034);
    chk("scratch byte", 16'h0008, {8'h00, rd});
    acc(3'h6, 3'h0, 16'h0014, 8'h00, 3'h3);
    acc(3'h7, 3'h0, 16'h0014, 8'h00, 3'h3);
    chk("bit clear", 16'h0000, {15'h0000, bv});
    acc(3'h5, 3'h0, 16'h0020);
    chk("bit above range", 16'h0001, {15'h0000, il});
    acc(3'h5, 3'h0, 16'h001F);
    chk("bit at 0x1F", 16'h0000, {15'h0000, il});
  endtask
  task t_unmap;
    acc(3'h2, 3'h0, 16'h0500, 8'hEE);
    acc(3'h1, 3'h0, 16'h0500);
    chk("unmapped", 16'h0000, {8'h00, rd});
    acc(3'h1, 3'h0, 16'h04FF);
    chk("sram kept", 16'h00C3, {8'h00, rd});
    acc(3'h1, 3'h0, 16'h00FF);
    chk("absent io", 16'h0000, {8'h00, rd});
  endtask
  task t_pcnv;
    int n;
    @(posedge clk);
    pcLoad <= 1'b1;
    pcValue <= 16'hFFFF;
    nvAddrIn <= 8'hFF;
    @(posedge clk);
    pcLoad <= 1'b0;
    #1;
    chk("programCounter", 16'h1FFF, {3'h0, programCounter});
    chk("nvAddr", 16'h00FF, {8'h00, nvAddr});
    for (n = 0; n < 40 && nvTick !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (nvTick !== 1'b1 && n < 40);
    chk("tick gap", 16'h001F, 16'(n));
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      complete_run;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_sram;
    t_io;
    t_bits;
    t_unmap;
    t_pcnv;
    complete_run;
  end
endmodule
